// file: include/rfs_map.svh
// Constants for the reference failover select block and its host controller.
`ifndef RFS_MAP_SVH
`define RFS_MAP_SVH

// Clock period of aclk in nanoseconds.
`define RFS_CLK_NS         10

// Phase error thresholds of the lock-loss detector, in nanoseconds.
`define RFS_LOL_SET_NS     4
`define RFS_LOL_CLR_NS     2

// Least high time of the lock-loss flag, and its count of cycles rounded up.
`define RFS_LOL_MIN_NS     10
`define RFS_LOL_MIN_CYC    ((`RFS_LOL_MIN_NS + `RFS_CLK_NS - 1) / `RFS_CLK_NS)

// Hold-off before re-arming after a switch or after reset, in milliseconds.
`define RFS_REARM_MS       500
`define RFS_REARM_CYC      ((`RFS_REARM_MS * 1000000) / `RFS_CLK_NS)

// Width of the lock-loss high-time counter.
`define RFS_LOL_CNT_W      4

// AXI4-Lite address width and register byte offsets of the host.
`define RFS_AXI_AW         8
`define RFS_CTRL_OFS       8'h00
`define RFS_STATUS_OFS     8'h04
`define RFS_IRQ_STAT_OFS   8'h08
`define RFS_IRQ_MASK_OFS   8'h0C

// Control register fields.
`define RFS_CTRL_AUTO_BIT  0
`define RFS_CTRL_CHOICE_BIT 1
`define RFS_CTRL_W         2

// Event bits of the interrupt status and mask registers.
`define RFS_EV_SWITCH_BIT  0
`define RFS_EV_LOL_RISE_BIT 1
`define RFS_EV_LOL_FALL_BIT 2
`define RFS_EV_W           3

// AXI response codes.
`define RFS_RESP_OKAY      2'h0
`define RFS_RESP_SLVERR    2'h2

`endif

// file: include/rfs_pkg.sv
// Types shared by the reference failover select device and host.
package rfs_pkg;

   // Selection state of the device.
   typedef enum logic [1:0] {
      RFS_MANUAL,
      RFS_ARMED,
      RFS_SWITCHED
   } rfs_state_t;

endpackage

// file: include/rfs_if.sv
// Pin level link between the failover device and its host controller.
`timescale 1ns/1ps

interface rfs_if;
   logic auto_mode;       // Mode pin: high asks for automatic failover.
   logic ref_choice;      // Reference choice pin: 0 picks input zero.
   logic lock_loss_flag;  // High while the PLL is out of lock.
   logic ref_in_use;      // 1 while input one is routed, 0 for input zero.

   modport dev (
      input  auto_mode,
      input  ref_choice,
      output lock_loss_flag,
      output ref_in_use
   );

   modport host (
      output auto_mode,
      output ref_choice,
      input  lock_loss_flag,
      input  ref_in_use
   );
endinterface

// file: src/rfs_device.sv
// Reference failover select logic of the clock device.
//
// Summary of operation
// R1 - Arm only while mode high, lock-loss low.
// R2 - Armed lock-loss rise switches to other input.
// R3 - One switch per arming, never back.
// R4 - Re-arm only via mode low then high.
// R5 - Manual mode: choice pin selects, 0 input zero.
// R6 - Host holds choice steady while arming, armed.
// R7 - Reference-in-use output always shows routed input.
// R8 - Switch shows toggle plus lock-loss 10 ns pulse.
// R9 - Unlockable new input: flag stays high, no switch.
// R10 - After switch, choice pin ignored until mode low.
// R11 - Host re-arms only with choice set, flag low.
// R12 - Host waits about 500 ms before re-arming.
// R13 - Host powers up in manual mode, lets settle.
// R14 - Flag high above 4 ns error, low below 2 ns.
// R15 - In-use output 1 for input one, 0 zero.
// R16 - Pins synchronized; flag rising edge triggers switch.
`timescale 1ns/1ps
`include "rfs_map.svh"

module rfs_device #(
   parameter int ERR_W = 8
) (
   input  wire logic             aclk,
   input  wire logic             aresetn,
   rfs_if.dev                    link,
   input  wire logic [ERR_W-1:0] phase_err_ns,
   output logic                  ref_sel,
   output logic                  armed,
   output logic                  switched
);

   // Thresholds at the width of the phase error input.
   localparam logic [ERR_W-1:0] SET_TH = ERR_W'(`RFS_LOL_SET_NS);
   localparam logic [ERR_W-1:0] CLR_TH = ERR_W'(`RFS_LOL_CLR_NS);

   // Least number of cycles that the flag stays high, less one.
   localparam logic [`RFS_LOL_CNT_W-1:0] LOL_HOLD =
      `RFS_LOL_CNT_W'(`RFS_LOL_MIN_CYC - 1);
   localparam logic [`RFS_LOL_CNT_W-1:0] LOL_CNT_MAX =
      {`RFS_LOL_CNT_W{1'b1}};

   logic                        mode_meta_r;
   logic                        mode_s_r;
   logic                        choice_meta_r;
   logic                        choice_s_r;
   logic                        lol_r;
   logic                        lol_prev_r;
   logic [`RFS_LOL_CNT_W-1:0]   lol_cnt_r;
   logic                        lol_rise;
   logic                        ref_in_use_r;
   rfs_pkg::rfs_state_t         state_r;

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisers
   ////////////////////////////////////////////////////////////////////////////

   // Two-stage synchroniser for the mode pin; only the second stage is used.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_meta_r <= 1'b0;
         mode_s_r    <= 1'b0;
      end else begin
         mode_meta_r <= link.auto_mode;   // see R16
         mode_s_r    <= mode_meta_r;
      end
   end

   // Two-stage synchroniser for the reference choice pin.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         choice_meta_r <= 1'b0;
         choice_s_r    <= 1'b0;
      end else begin
         choice_meta_r <= link.ref_choice; // see R16
         choice_s_r    <= choice_meta_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Lock-loss detector
   ////////////////////////////////////////////////////////////////////////////

   // Hysteresis on the phase error keeps the flag from chattering between
   // the two thresholds; the counter enforces the least high time.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lol_r <= 1'b0;
      end else if (!lol_r) begin
         if (phase_err_ns > SET_TH) begin
            lol_r <= 1'b1;                // see R14
         end
      end else if (phase_err_ns < CLR_TH && lol_cnt_r >= LOL_HOLD) begin
         lol_r <= 1'b0;                   // see R14, see R8
      end
   end

   // Counts the cycles for which the flag has been high, saturating.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lol_cnt_r <= '0;
      end else if (!lol_r) begin
         lol_cnt_r <= '0;
      end else if (lol_cnt_r != LOL_CNT_MAX) begin
         lol_cnt_r <= lol_cnt_r + 1'b1;   // see R8
      end
   end

   // Previous flag value for the rising edge detector.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lol_prev_r <= 1'b0;
      end else begin
         lol_prev_r <= lol_r;
      end
   end

   // A rising edge of the flag is the fault event that triggers a switch.
   assign lol_rise = lol_r & ~lol_prev_r;  // see R16

   ////////////////////////////////////////////////////////////////////////////
   // Selection state machine
   ////////////////////////////////////////////////////////////////////////////

   // Manual mode arms once mode is high with the flag low; a fault while
   // armed moves to the switched state, which only mode low can leave.
   // If mode rises while the flag is high, arming waits for the flag to fall.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r <= rfs_pkg::RFS_MANUAL;
      end else begin
         unique case (state_r)
            rfs_pkg::RFS_MANUAL: begin
               if (mode_s_r && !lol_r) begin
                  state_r <= rfs_pkg::RFS_ARMED;     // see R1
               end
            end
            rfs_pkg::RFS_ARMED: begin
               if (!mode_s_r) begin
                  state_r <= rfs_pkg::RFS_MANUAL;    // see R4
               end else if (lol_rise) begin
                  state_r <= rfs_pkg::RFS_SWITCHED;  // see R2
               end
            end
            rfs_pkg::RFS_SWITCHED: begin
               if (!mode_s_r) begin
                  state_r <= rfs_pkg::RFS_MANUAL;    // see R3, see R4
               end
            end
            default: begin
               state_r <= rfs_pkg::RFS_MANUAL;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Reference routing
   ////////////////////////////////////////////////////////////////////////////

   // In manual mode the choice pin steers the mux directly, so its level at
   // arming is the initial input. Armed, the first fault flips the mux once.
   // In the switched state the mux holds and the choice pin is ignored, so
   // a new input that cannot lock keeps the flag high with no second switch.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ref_in_use_r <= 1'b0;
      end else begin
         unique case (state_r)
            rfs_pkg::RFS_MANUAL: begin
               ref_in_use_r <= choice_s_r;           // see R5
            end
            rfs_pkg::RFS_ARMED: begin
               if (mode_s_r && lol_rise) begin
                  ref_in_use_r <= ~ref_in_use_r;     // see R2, see R8
               end
            end
            rfs_pkg::RFS_SWITCHED: begin
               ref_in_use_r <= ref_in_use_r;         // see R3, see R9, see R10
            end
            default: begin
               ref_in_use_r <= choice_s_r;
            end
         endcase
      end
   end

   // Registered state indications for the user side.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         armed    <= 1'b0;
         switched <= 1'b0;
      end else begin
         armed    <= (state_r == rfs_pkg::RFS_ARMED);
         switched <= (state_r == rfs_pkg::RFS_SWITCHED);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   ////////////////////////////////////////////////////////////////////////////

   // The mux select and the in-use pin come from one flop, so the pin never
   // disagrees with the routed input; 1 means input one.
   assign ref_sel             = ref_in_use_r;  // see R7, see R15
   assign link.ref_in_use     = ref_in_use_r;  // see R7, see R15
   assign link.lock_loss_flag = lol_r;

endmodule // rfs_device

// file: src/rfs_host.sv
// Host controller driving the failover pins, with an AXI4-Lite register port.
//
// Chosen here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "rfs_map.svh"

module rfs_host #(
   parameter int unsigned REARM_CYC = `RFS_REARM_CYC
) (
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   input  wire logic [`RFS_AXI_AW-1:0] s_axi_awaddr,
   input  wire logic                   s_axi_awvalid,
   output logic                        s_axi_awready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output logic                        s_axi_wready,
   output logic [1:0]                  s_axi_bresp,
   output logic                        s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   input  wire logic [`RFS_AXI_AW-1:0] s_axi_araddr,
   input  wire logic                   s_axi_arvalid,
   output logic                        s_axi_arready,
   output logic [31:0]                 s_axi_rdata,
   output logic [1:0]                  s_axi_rresp,
   output logic                        s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   rfs_if.host                         link,
   output logic                        irq
);

   logic [`RFS_AXI_AW-1:0] awaddr_r;
   logic [31:0]            wdata_r;
   logic                   wstrb0_r;
   logic                   aw_got_r;
   logic                   w_got_r;
   logic                   wr_do;
   logic                   wr_ok;
   logic [`RFS_CTRL_W-1:0] ctrl_r;
   logic [`RFS_EV_W-1:0]   irq_stat_r;
   logic [`RFS_EV_W-1:0]   irq_mask_r;
   logic [`RFS_EV_W-1:0]   ev;
   logic [`RFS_EV_W-1:0]   w1c;
   logic                   mode_r;
   logic                   choice_r;
   logic                   lol_prev_r;
   logic                   ref_prev_r;
   logic [31:0]            hold_r;
   logic [31:0]            status;

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write channel
   ////////////////////////////////////////////////////////////////////////////

   // Address and data are taken in either order; the write happens once
   // both are held and no response is pending.
   assign wr_do = aw_got_r && w_got_r && !s_axi_bvalid;
   assign wr_ok = (awaddr_r == `RFS_CTRL_OFS) ||
                  (awaddr_r == `RFS_STATUS_OFS) ||
                  (awaddr_r == `RFS_IRQ_STAT_OFS) ||
                  (awaddr_r == `RFS_IRQ_MASK_OFS);

   // Write address and data capture.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         aw_got_r      <= 1'b0;
         w_got_r       <= 1'b0;
         awaddr_r      <= '0;
         wdata_r       <= '0;
         wstrb0_r      <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awaddr_r      <= s_axi_awaddr;
            aw_got_r      <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wdata_r      <= s_axi_wdata;
            wstrb0_r     <= s_axi_wstrb[0];
            w_got_r      <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (wr_do) begin
            aw_got_r <= 1'b0;
            w_got_r  <= 1'b0;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // Write response; unmapped offsets answer SLVERR.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `RFS_RESP_OKAY;
      end else if (wr_do) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_ok ? `RFS_RESP_OKAY : `RFS_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Control and mask registers, written through byte lane 0.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r     <= '0;
         irq_mask_r <= '0;
      end else if (wr_do && wstrb0_r) begin
         if (awaddr_r == `RFS_CTRL_OFS) begin
            ctrl_r <= wdata_r[`RFS_CTRL_W-1:0];
         end
         if (awaddr_r == `RFS_IRQ_MASK_OFS) begin
            irq_mask_r <= wdata_r[`RFS_EV_W-1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Events and interrupt
   ////////////////////////////////////////////////////////////////////////////

   // Edge history of the device outputs.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lol_prev_r <= 1'b0;
         ref_prev_r <= 1'b0;
      end else begin
         lol_prev_r <= link.lock_loss_flag;
         ref_prev_r <= link.ref_in_use;
      end
   end

   // An in-use change while mode is high is an automatic switch.
   always_comb begin
      ev = '0;
      ev[`RFS_EV_SWITCH_BIT]   = mode_r && (link.ref_in_use != ref_prev_r);
      ev[`RFS_EV_LOL_RISE_BIT] = link.lock_loss_flag && !lol_prev_r;
      ev[`RFS_EV_LOL_FALL_BIT] = !link.lock_loss_flag && lol_prev_r;
   end

   assign w1c = (wr_do && wstrb0_r && awaddr_r == `RFS_IRQ_STAT_OFS) ?
                wdata_r[`RFS_EV_W-1:0] : '0;

   // Sticky status: a new event wins over a clear in the same cycle.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_stat_r <= '0;
      end else begin
         irq_stat_r <= (irq_stat_r & ~w1c) | ev;
      end
   end

   // Level interrupt, high while any unmasked status bit is set.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_stat_r & irq_mask_r);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin control
   ////////////////////////////////////////////////////////////////////////////

   // Re-arm hold-off, loaded at reset and at each automatic switch.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hold_r <= REARM_CYC;                       // see R13
      end else if (ev[`RFS_EV_SWITCH_BIT]) begin
         hold_r <= REARM_CYC;                       // see R12
      end else if (hold_r != 32'h0000_0000) begin
         hold_r <= hold_r - 32'h0000_0001;
      end
   end

   // Mode drops at once; it rises only once the choice pin already shows
   // the wanted input, the flag is low and the hold-off has run out.
   // Waiting for the in-use pin to match keeps a late manual change from
   // being taken for an automatic switch.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_r <= 1'b0;                            // see R13
      end else if (!ctrl_r[`RFS_CTRL_AUTO_BIT]) begin
         mode_r <= 1'b0;                            // see R4
      end else if (!mode_r && !link.lock_loss_flag &&
                   hold_r == 32'h0000_0000 &&
                   link.ref_in_use == choice_r &&
                   choice_r == ctrl_r[`RFS_CTRL_CHOICE_BIT]) begin
         mode_r <= 1'b1;                            // see R11, see R12
      end
   end

   // The choice pin moves only while mode is low, so it is steady at arming.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         choice_r <= 1'b0;
      end else if (!mode_r) begin
         choice_r <= ctrl_r[`RFS_CTRL_CHOICE_BIT];  // see R6
      end
   end

   assign link.auto_mode  = mode_r;
   assign link.ref_choice = choice_r;

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read channel
   ////////////////////////////////////////////////////////////////////////////

   assign status = {27'h0, (hold_r != 32'h0000_0000), mode_r, choice_r,
                    link.ref_in_use, link.lock_loss_flag};

   // One read at a time; data follows one cycle after the address is taken.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= `RFS_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= `RFS_RESP_OKAY;
         unique case (s_axi_araddr)
            `RFS_CTRL_OFS:     s_axi_rdata <= {30'h0, ctrl_r};
            `RFS_STATUS_OFS:   s_axi_rdata <= status;
            `RFS_IRQ_STAT_OFS: s_axi_rdata <= {29'h0, irq_stat_r};
            `RFS_IRQ_MASK_OFS: s_axi_rdata <= {29'h0, irq_mask_r};
            default: begin
               s_axi_rdata <= '0;
               s_axi_rresp <= `RFS_RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

endmodule // rfs_host

// file: tb/rfs_properties.sv
// Checker of the failover pins between the host and the device.
`timescale 1ns/1ps

module rfs_properties #(
   parameter int unsigned REARM_CYC = 20
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic auto_mode,
   input wire logic ref_choice,
   input wire logic lock_loss_flag,
   input wire logic ref_in_use
);
   logic [5:0]  mode_hist_r;
   logic        use_d_r;
   logic        sw_r;
   int unsigned hold_r;
   logic        sw_ev;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   ////////////////////////////////////////////////////////////////////////
   // A switch is an in-use change after the mode pin stood high a while.
   assign sw_ev = (ref_in_use != use_d_r) && (&mode_hist_r) && auto_mode;

   // Mode pin history and the last in-use level.
   always_ff @(posedge aclk) begin
      mode_hist_r <= aresetn ? {mode_hist_r[4:0], auto_mode} : 6'h00;
      use_d_r     <= ref_in_use;
   end

   // Remembers that this arming has already been spent.
   always_ff @(posedge aclk) begin
      if (!aresetn || !auto_mode) begin
         sw_r <= 1'h0;
      end else if (sw_ev) begin
         sw_r <= 1'h1;
      end
   end

   // Hold-off count; a small margin allows for the host's own detection.
   always_ff @(posedge aclk) begin
      if (!aresetn || sw_ev) begin
         hold_r <= REARM_CYC - 3;
      end else if (hold_r != 0) begin
         hold_r <= hold_r - 1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   a_manual_follow: assert property (mode_hist_r == 6'h00 && !auto_mode
      |-> ref_in_use == $past(ref_choice, 3))
      else $error("in-use output does not follow the choice pin");
   a_toggle_on_loss: assert property ($rose(lock_loss_flag)
      && (&mode_hist_r) && auto_mode && !sw_r && !$past(lock_loss_flag, 2)
      |=> ref_in_use != $past(ref_in_use))
      else $error("armed loss of lock did not switch input");
   a_switch_needs_rise: assert property ($changed(ref_in_use)
      && (&mode_hist_r) && auto_mode
      |-> $past(lock_loss_flag) && !$past(lock_loss_flag, 2))
      else $error("input switched without a lock-loss rise");
   a_one_switch_only: assert property (sw_r && auto_mode
      |-> $stable(ref_in_use))
      else $error("second switch within one arming");
   a_choice_held: assert property (auto_mode && $past(auto_mode)
      |-> $stable(ref_choice))
      else $error("choice pin moved in automatic mode");
   a_arm_flag_low: assert property ($rose(auto_mode)
      |-> !$past(lock_loss_flag))
      else $error("mode raised while flag high");
   a_rearm_holdoff: assert property ($rose(auto_mode) |-> hold_r == 0)
      else $error("mode raised inside the hold-off");
   a_powerup_manual: assert property ($rose(aresetn)
      |-> !auto_mode && !lock_loss_flag && !ref_in_use)
      else $error("pins not idle after reset");

   // Main scenarios.
   c_switch: cover property (sw_ev);
   c_arm: cover property ($rose(auto_mode));
   c_loss_spent: cover property ($rose(lock_loss_flag) && sw_r);
endmodule // rfs_properties

// file: tb/testbench.sv
// Testbench joining host and device through the pin interface.
`timescale 1ns/1ps
`include "rfs_map.svh"

module testbench;
   localparam int unsigned RC = 20;
   logic        aclk = 1'h0;
   logic        aresetn = 1'h0;
   logic [7:0]  awaddr = 8'h00;
   logic        awvalid = 1'h0;
   logic [31:0] wdata = 32'h0;
   logic        wvalid = 1'h0;
   logic        bready = 1'h0;
   logic [7:0]  araddr = 8'h00;
   logic        arvalid = 1'h0;
   logic        rready = 1'h0;
   logic [7:0]  phase_err_ns = 8'h00;
   logic        awready, wready, bvalid, arready, rvalid, irq, switched;
   logic        armed, ref_sel;
   logic [1:0]  bresp, rresp, r;
   logic [31:0] rdata, d;
   int          n_errors = 0;
   int          n_compared = 0;
   int          cyc = 0;

   rfs_if link ();

   rfs_host #(.REARM_CYC(RC)) i_rfs_host (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .link(link.host), .irq(irq));

   rfs_device i_rfs_device (.aclk(aclk), .aresetn(aresetn),
      .link(link.dev), .phase_err_ns(phase_err_ns), .ref_sel(ref_sel),
      .armed(armed), .switched(switched));

   rfs_properties #(.REARM_CYC(RC)) i_rfs_properties (.aclk(aclk),
      .aresetn(aresetn), .auto_mode(link.auto_mode),
      .ref_choice(link.ref_choice), .lock_loss_flag(link.lock_loss_flag),
      .ref_in_use(link.ref_in_use));

   ////////////////////////////////////////////////////////////////////////
   // Clock of 10 ns.
   initial begin
      forever #5 aclk = ~aclk;
   end

   // Cuts a hang short.
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 5000) begin
         n_errors++;
         test_done();
      end
   end

   task automatic test_done();
      if (n_errors == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] got,
                      input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("FAIL %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // One write; address and data offered together, each dropped when taken.
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
      end while (bvalid !== 1'h1);
      r = bresp;
      bready <= 1'h0;
   endtask

   // One read; data and response taken at the edge that shows rvalid.
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'h0;
      end while (rvalid !== 1'h1);
      d = rdata;
      r = rresp;
      rready <= 1'h0;
   endtask

   task automatic wait_mode(input logic v);
      while (link.auto_mode !== v) @(posedge aclk);
      repeat (6) @(posedge aclk);
   endtask

   // Phase error for n cycles, then back to lock.
   task automatic fault(input logic [7:0] e, input int n);
      phase_err_ns <= e;
      repeat (n) @(posedge aclk);
      phase_err_ns <= 8'h00;
      repeat (8) @(posedge aclk);
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      rd(`RFS_STATUS_OFS);
      chk("status", d, 32'h10);
      rd(8'h10);
      chk("bad rresp", {30'h0, r}, {30'h0, `RFS_RESP_SLVERR});
      chk("bad rdata", d, 32'h0);
      wr(8'h10, 32'h1);
      chk("bad bresp", {30'h0, r}, {30'h0, `RFS_RESP_SLVERR});
   endtask

   task automatic t_manual();
      repeat (RC) @(posedge aclk);
      wr(`RFS_CTRL_OFS, 32'h2);
      repeat (8) @(posedge aclk);
      chk("manual one", link.ref_in_use, 1);
      rd(`RFS_STATUS_OFS);
      chk("status one", d, 32'h06);
      wr(`RFS_CTRL_OFS, 32'h0);
      repeat (8) @(posedge aclk);
      chk("manual zero", link.ref_in_use, 0);
   endtask

   task automatic t_switch();
      wr(`RFS_IRQ_MASK_OFS, 32'h1);
      wr(`RFS_CTRL_OFS, 32'h1);
      wait_mode(1'h1);
      chk("armed", armed, 1);
      fault(8'h05, 1);
      chk("switch", link.ref_in_use, 1);
      chk("sel", ref_sel, 1);
      chk("disarmed", armed, 0);
      chk("relock", link.lock_loss_flag, 0);
      chk("irq on", irq, 1);
      rd(`RFS_IRQ_STAT_OFS);
      chk("events", d, 32'h7);
      wr(`RFS_IRQ_STAT_OFS, 32'h7);
      repeat (2) @(posedge aclk);
      chk("irq off", irq, 0);
      fault(8'h05, 1);
      chk("one shot", link.ref_in_use, 1);
      chk("spent", switched, 1);
   endtask

   task automatic t_rearm();
      wr(`RFS_IRQ_MASK_OFS, 32'h0);
      wr(`RFS_CTRL_OFS, 32'h2);
      wait_mode(1'h0);
      wr(`RFS_CTRL_OFS, 32'h3);
      wait_mode(1'h1);
      chk("rearm keep", link.ref_in_use, 1);
      phase_err_ns <= 8'h09;
      repeat (20) @(posedge aclk);
      chk("bad input", link.ref_in_use, 0);
      chk("bad sel", ref_sel, 0);
      chk("stuck flag", link.lock_loss_flag, 1);
      chk("masked", irq, 0);
      wr(`RFS_IRQ_MASK_OFS, 32'h1);
      repeat (2) @(posedge aclk);
      chk("unmasked", irq, 1);
      fault(8'h00, 1);
   endtask

   // Main sequence.
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'h1;
      t_regs();
      t_manual();
      t_switch();
      t_rearm();
      test_done();
   end
endmodule // testbench
